// ---- cae_exec.sv ----
// Package and combinational execute unit for the conditional ALU and compare group
package cae_pkg;
  localparam int          XLEN       = 32;
  localparam int          NREG       = 16;
  localparam int          SHAMT_W    = 6;
  localparam logic [7:0]  OPC_ADDIF  = 8'h3a;
  localparam logic [7:0]  OPC_ADDF   = 8'h3b;
  localparam logic [7:0]  OPC_ADDIT  = 8'h3e;
  localparam logic [7:0]  OPC_ADDT   = 8'h3f;
  localparam logic [7:0]  OPC_AND    = 8'h25;
  localparam logic [3:0]  OPC_ANDI   = 4'h5;
  localparam logic [7:0]  OPC_ASR    = 8'h0d;
  localparam logic [7:0]  OPC_ASRI   = 8'h0f;
  localparam logic [7:0]  OPC_CMPEQI = 8'h30;
  localparam logic [7:0]  OPC_CMPEQ  = 8'h31;
  localparam logic [7:0]  OPC_CMPHS  = 8'h32;
  localparam logic [7:0]  OPC_CMPLS  = 8'h33;
  localparam logic [7:0]  OPC_CMPLT  = 8'h34;
  localparam logic [7:0]  OPC_CMPGT  = 8'h35;
  localparam logic [7:0]  OPC_CMPLTI = 8'h36;
  localparam logic [7:0]  OPC_CMPGTI = 8'h37;
  localparam int          OPC_MSB    = 15;
  localparam int          OPC_LSB    = 8;
  localparam int          DST_MSB    = 7;
  localparam int          DST_LSB    = 4;
  localparam int          SRC_MSB    = 3;
  localparam int          SRC_LSB    = 0;
  localparam logic        TF_RST     = 1'b0;
  localparam logic        CY_RST     = 1'b0;
  localparam logic [31:0] REG_RST    = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_NONE   = 5'b00000,
    OP_ADDIF  = 5'b00001,
    OP_ADDIT  = 5'b00010,
    OP_ADDT   = 5'b00011,
    OP_ADDF   = 5'b00100,
    OP_AND    = 5'b00101,
    OP_ANDI   = 5'b00110,
    OP_ASR    = 5'b00111,
    OP_ASRI   = 5'b01000,
    OP_CMPEQ  = 5'b01001,
    OP_CMPEQI = 5'b01010,
    OP_CMPGT  = 5'b01011,
    OP_CMPGTI = 5'b01100,
    OP_CMPHS  = 5'b01101,
    OP_CMPLS  = 5'b01110,
    OP_CMPLT  = 5'b01111,
    OP_CMPLTI = 5'b10000
  } cae_op_e;

  typedef struct packed {
    logic       valid;
    cae_op_e    op;
    logic [3:0] dst;
    logic [3:0] src;
    logic [7:0] imm;
  } cae_dec_s;

  typedef struct packed {
    logic        reg_we;
    logic [3:0]  addr;
    logic [31:0] data;
    logic        flag_we;
    logic        flag;
    logic        illegal;
  } cae_res_s;

  function automatic logic [31:0] sext4(input logic [3:0] v);
    return {{28{v[3]}}, v};
  endfunction
endpackage

`timescale 1ns/1ps
module cae_exec (
  input  wire cae_pkg::cae_dec_s dec_i,
  input  wire logic [31:0]       rd_val_i,
  input  wire logic [31:0]       rb_val_i,
  input  wire logic              tf_i,
  output cae_pkg::cae_res_s      res_o
);
  logic [31:0] simm;
  logic [31:0] uimm;
  logic [31:0] asr_dyn;
  logic [31:0] asr_imm;

  assign simm = cae_pkg::sext4(dec_i.imm[3:0]);
  assign uimm = {24'h000000, dec_i.imm};
  // Six-bit amounts of 32 to 63 give pure sign fill; bits above bit 5 are ignored
  assign asr_dyn = (rb_val_i[5:0] > 6'h1f) ? {32{rd_val_i[31]}} :
                   32'($signed(rd_val_i) >>> rb_val_i[4:0]);
  assign asr_imm = 32'($signed(rd_val_i) >>> dec_i.imm[3:0]);

  always_comb
  begin
    res_o         = '0;
    res_o.addr    = dec_i.dst;
    res_o.data    = rd_val_i;
    // Arithmetic ops never touch the flag path
    if (dec_i.valid)
    begin
      case (dec_i.op)
        cae_pkg::OP_ADDIF:
        begin
          res_o.reg_we = ~tf_i;
          res_o.data   = rd_val_i + simm;
        end
        cae_pkg::OP_ADDIT:
        begin
          res_o.reg_we = tf_i;
          res_o.data   = rd_val_i + simm;
        end
        cae_pkg::OP_ADDT:
        begin
          res_o.reg_we = tf_i;
          res_o.data   = rd_val_i + rb_val_i;
        end
        cae_pkg::OP_ADDF:
        begin
          res_o.reg_we = ~tf_i;
          res_o.data   = rd_val_i + rb_val_i;
        end
        cae_pkg::OP_AND:
        begin
          res_o.reg_we = 1'b1;
          res_o.data   = rd_val_i & rb_val_i;
        end
        cae_pkg::OP_ANDI:
        begin
          res_o.reg_we = 1'b1;
          res_o.data   = rd_val_i & uimm;
        end
        cae_pkg::OP_ASR:
        begin
          res_o.reg_we = 1'b1;
          res_o.data   = asr_dyn;
        end
        cae_pkg::OP_ASRI:
        begin
          res_o.reg_we = 1'b1;
          res_o.data   = asr_imm;
        end
        // Compares write the flag only
        cae_pkg::OP_CMPEQ:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = (rd_val_i == rb_val_i);
        end
        cae_pkg::OP_CMPEQI:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = (rd_val_i == simm);
        end
        cae_pkg::OP_CMPGT:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = ($signed(rd_val_i) > $signed(rb_val_i));
        end
        cae_pkg::OP_CMPGTI:
        begin
          // Unsigned on purpose: negative immediates become large values
          res_o.flag_we = 1'b1;
          res_o.flag    = (rd_val_i > simm);
        end
        cae_pkg::OP_CMPHS:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = (rd_val_i >= rb_val_i);
        end
        cae_pkg::OP_CMPLS:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = (rd_val_i <= rb_val_i);
        end
        cae_pkg::OP_CMPLT:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = ($signed(rd_val_i) < $signed(rb_val_i));
        end
        cae_pkg::OP_CMPLTI:
        begin
          res_o.flag_we = 1'b1;
          res_o.flag    = ($signed(rd_val_i) < $signed(simm));
        end
        default:
        begin
          res_o.illegal = 1'b1;
        end
      endcase
    end
  end
endmodule

// ---- cae_top.sv ----
// Decode, register file and status flags for the conditional ALU and compare group
//
// Summary of operation
// - addif adds signed nibble when flag clear
// - addit adds signed nibble when flag set
// - addt adds source register when flag set
// - Adds, ands, shifts leave status flags alone
// - and replaces destination with destination AND source
// - andi masks destination with zero-extended byte
// - asr shifts by source low six bits
// - Shift above 31 gives pure sign fill
// - asri shifts by unsigned nibble 0..15
// - cmpeq sets flag on register equality
// - cmpeqi sets flag on equality with nibble
// - cmpgt signed greater-than sets flag
// - cmpgti unsigned greater than extended nibble
// - cmphs unsigned higher-or-same sets flag
// - cmpls unsigned lower-or-same sets flag
// - cmplt signed less-than sets flag
// - cmplti signed less than extended nibble
// - Compares write only flag, never registers
// - addf adds source register when flag clear
`timescale 1ns/1ps
module cae_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        INSTR_VALID_I,
  input  wire logic [15:0] INSTR_I,
  input  wire logic        EXT_REG_WE_I,
  input  wire logic [3:0]  EXT_REG_ADDR_I,
  input  wire logic [31:0] EXT_REG_DATA_I,
  input  wire logic        EXT_FLAG_WE_I,
  input  wire logic        EXT_FLAG_I,
  input  wire logic        EXT_CARRY_WE_I,
  input  wire logic        EXT_CARRY_I,
  input  wire logic [3:0]  RD_ADDR_I,
  output logic [31:0]      RD_DATA_O,
  output logic             TRUE_FALSE_FLAG_O,
  output logic             CARRY_FLAG_O,
  output logic             WB_VALID_O,
  output logic [3:0]       WB_ADDR_O,
  output logic [31:0]      WB_DATA_O,
  output logic             CMP_DONE_O,
  output logic             ILLEGAL_O
);
  logic [31:0]          regs_r [cae_pkg::NREG];
  logic                 true_false_flag_r;
  logic                 carry_flag_r;
  cae_pkg::cae_dec_s    dec;
  cae_pkg::cae_res_s    res;

  function automatic cae_pkg::cae_dec_s decode(input logic v, input logic [15:0] w);
    cae_pkg::cae_dec_s d;
    d       = '0;
    d.valid = v;
    d.dst   = w[cae_pkg::DST_MSB:cae_pkg::DST_LSB];
    d.src   = w[cae_pkg::SRC_MSB:cae_pkg::SRC_LSB];
    d.imm   = {4'h0, w[cae_pkg::SRC_MSB:cae_pkg::SRC_LSB]};
    if (w[15:12] == cae_pkg::OPC_ANDI)
    begin
      d.op  = cae_pkg::OP_ANDI;
      d.imm = {w[11:8], w[3:0]};
    end
    else
    begin
      case (w[cae_pkg::OPC_MSB:cae_pkg::OPC_LSB])
        cae_pkg::OPC_ADDIF:  d.op = cae_pkg::OP_ADDIF;
        cae_pkg::OPC_ADDIT:  d.op = cae_pkg::OP_ADDIT;
        cae_pkg::OPC_ADDT:   d.op = cae_pkg::OP_ADDT;
        cae_pkg::OPC_ADDF:   d.op = cae_pkg::OP_ADDF;
        cae_pkg::OPC_AND:    d.op = cae_pkg::OP_AND;
        cae_pkg::OPC_ASR:    d.op = cae_pkg::OP_ASR;
        cae_pkg::OPC_ASRI:   d.op = cae_pkg::OP_ASRI;
        cae_pkg::OPC_CMPEQ:  d.op = cae_pkg::OP_CMPEQ;
        cae_pkg::OPC_CMPEQI: d.op = cae_pkg::OP_CMPEQI;
        cae_pkg::OPC_CMPGT:  d.op = cae_pkg::OP_CMPGT;
        cae_pkg::OPC_CMPGTI: d.op = cae_pkg::OP_CMPGTI;
        cae_pkg::OPC_CMPHS:  d.op = cae_pkg::OP_CMPHS;
        cae_pkg::OPC_CMPLS:  d.op = cae_pkg::OP_CMPLS;
        cae_pkg::OPC_CMPLT:  d.op = cae_pkg::OP_CMPLT;
        cae_pkg::OPC_CMPLTI: d.op = cae_pkg::OP_CMPLTI;
        default:             d.op = cae_pkg::OP_NONE;
      endcase
    end
    return d;
  endfunction

  assign dec = decode(INSTR_VALID_I, INSTR_I);

  // Operands read straight from the array so back-to-back ops see fresh values
  cae_exec u_exec (
    .dec_i    (dec),
    .rd_val_i (regs_r[dec.dst]),
    .rb_val_i (regs_r[dec.src]),
    .tf_i     (true_false_flag_r),
    .res_o    (res)
  );

  // Executed op beats a same-cycle write from other groups
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < cae_pkg::NREG; i++)
      begin
        regs_r[i] <= cae_pkg::REG_RST;
      end
    end
    else
    begin
      if (EXT_REG_WE_I)
      begin
        regs_r[EXT_REG_ADDR_I] <= EXT_REG_DATA_I;
      end
      if (res.reg_we)
      begin
        regs_r[res.addr] <= res.data;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      true_false_flag_r <= cae_pkg::TF_RST;
    end
    else if (res.flag_we)
    begin
      true_false_flag_r <= res.flag;
    end
    else if (EXT_FLAG_WE_I)
    begin
      true_false_flag_r <= EXT_FLAG_I;
    end
  end

  // Carry belongs to other groups only
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      carry_flag_r <= cae_pkg::CY_RST;
    end
    else if (EXT_CARRY_WE_I)
    begin
      carry_flag_r <= EXT_CARRY_I;
    end
  end

  assign TRUE_FALSE_FLAG_O = true_false_flag_r;
  assign CARRY_FLAG_O      = carry_flag_r;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      WB_VALID_O <= 1'b0;
      WB_ADDR_O  <= 4'h0;
      WB_DATA_O  <= 32'h0000_0000;
      CMP_DONE_O <= 1'b0;
      ILLEGAL_O  <= 1'b0;
      RD_DATA_O  <= 32'h0000_0000;
    end
    else
    begin
      WB_VALID_O <= res.reg_we;
      WB_ADDR_O  <= res.addr;
      WB_DATA_O  <= res.data;
      CMP_DONE_O <= res.flag_we;
      ILLEGAL_O  <= res.illegal;
      RD_DATA_O  <= regs_r[RD_ADDR_I];
    end
  end
endmodule

// ---- cae_top_checker.sv ----
// Checker on the top ports of the conditional ALU and compare group
`timescale 1ns/1ps
module cae_top_checker (
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  input wire logic        INSTR_VALID_I,
  input wire logic [15:0] INSTR_I,
  input wire logic        EXT_FLAG_WE_I,
  input wire logic        EXT_CARRY_WE_I,
  input wire logic        TRUE_FALSE_FLAG_O,
  input wire logic        CARRY_FLAG_O,
  input wire logic        WB_VALID_O,
  input wire logic [3:0]  WB_ADDR_O,
  input wire logic        CMP_DONE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  logic [7:0] opc;
  logic       go;
  logic       same;
  logic       alu;
  logic       lgc;
  assign opc  = INSTR_I[15:8];
  assign go   = INSTR_VALID_I;
  assign same = INSTR_I[7:4] == INSTR_I[3:0];
  assign lgc  = opc inside {8'h25, 8'h0d, 8'h0f} || INSTR_I[15:12] == 4'h5;
  assign alu  = lgc || opc inside {8'h3a, 8'h3b, 8'h3e, 8'h3f};
  // Writeback lands one cycle after the instruction, at its own destination
  sequence s_wb_dst;
    WB_VALID_O && WB_ADDR_O == $past(INSTR_I[7:4]);
  endsequence
  sequence s_no_wb;
    !WB_VALID_O;
  endsequence
  addif_skip_a: assert property (go && opc == 8'h3a && TRUE_FALSE_FLAG_O |=> s_no_wb)
    else $error("addif wrote with flag set");
  addit_take_a: assert property (go && opc == 8'h3e && TRUE_FALSE_FLAG_O |=> s_wb_dst)
    else $error("addit missed its write");
  addt_skip_a: assert property (go && opc == 8'h3f && !TRUE_FALSE_FLAG_O |=> s_no_wb)
    else $error("addt wrote with flag clear");
  addf_take_a: assert property (go && opc == 8'h3b && !TRUE_FALSE_FLAG_O |=> s_wb_dst)
    else $error("addf missed its write");
  flag_hold_a: assert property (go && alu && !EXT_FLAG_WE_I |=> $stable(TRUE_FALSE_FLAG_O))
    else $error("alu op changed the flag");
  carry_hold_a: assert property (!EXT_CARRY_WE_I |=> $stable(CARRY_FLAG_O))
    else $error("carry changed without external write");
  logic_wb_a: assert property (go && lgc |=> s_wb_dst)
    else $error("logic or shift op missed its write");
  cmp_only_a: assert property (go && opc[7:3] == 5'b00110 |=> CMP_DONE_O && !WB_VALID_O)
    else $error("compare wrote a register or no done");
  cmp_self_a: assert property (go && opc inside {8'h31, 8'h32, 8'h33} && same |=> TRUE_FALSE_FLAG_O)
    else $error("inclusive compare of a register with itself gave 0");
  cmp_strict_a: assert property (go && opc inside {8'h34, 8'h35} && same |=> !TRUE_FALSE_FLAG_O)
    else $error("strict compare of a register with itself gave 1");
endmodule

bind cae_top cae_top_checker u_cae_top_checker (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .EXT_FLAG_WE_I(EXT_FLAG_WE_I),
  .EXT_CARRY_WE_I(EXT_CARRY_WE_I), .TRUE_FALSE_FLAG_O(TRUE_FALSE_FLAG_O),
  .CARRY_FLAG_O(CARRY_FLAG_O), .WB_VALID_O(WB_VALID_O), .WB_ADDR_O(WB_ADDR_O),
  .CMP_DONE_O(CMP_DONE_O));

// ---- cae_top_test.sv ----
// Self-checking bench for the conditional ALU and compare group
`timescale 1ns/1ps
module cae_top_test;
  logic        clk, rst, iv, rwe, fwe, fv, cwe, cv, tf, cy, wbv, cmpd, ill;
  logic [15:0] ins;
  logic [3:0]  radr, rda, wba;
  logic [31:0] rdat, rdo, wbd;
  int          miscompares;
  int          n_checks;
  // Instruction, destination value, source value, expected flag
  localparam logic [80:0] CMP_TAB [18] = '{
    {16'h3189, 32'h5, 32'h5, 1'b1}, {16'h3189, 32'h5, 32'h6, 1'b0},
    {16'h3589, 32'h1, 32'hffffffff, 1'b1}, {16'h3589, 32'hffffffff, 32'h1, 1'b0},
    {16'h3289, 32'hffffffff, 32'h1, 1'b1}, {16'h3289, 32'h1, 32'h2, 1'b0},
    {16'h3389, 32'h1, 32'hffffffff, 1'b1}, {16'h3389, 32'h3, 32'h3, 1'b1},
    {16'h3489, 32'h80000000, 32'h0, 1'b1}, {16'h3489, 32'h0, 32'h0, 1'b0},
    {16'h3088, 32'hfffffff8, 32'h0, 1'b1}, {16'h3087, 32'h6, 32'h0, 1'b0},
    {16'h3787, 32'h10, 32'h0, 1'b1}, {16'h378f, 32'h5, 32'h0, 1'b0},
    {16'h368f, 32'hfffffff0, 32'h0, 1'b1}, {16'h3688, 32'h0, 32'h0, 1'b0},
    {16'h3288, 32'h9, 32'h0, 1'b1}, {16'h3488, 32'h9, 32'h0, 1'b0}};
  cae_top u_cae_top (.CLOCK_I(clk), .RST_I(rst), .INSTR_VALID_I(iv), .INSTR_I(ins),
    .EXT_REG_WE_I(rwe), .EXT_REG_ADDR_I(radr), .EXT_REG_DATA_I(rdat), .EXT_FLAG_WE_I(fwe),
    .EXT_FLAG_I(fv), .EXT_CARRY_WE_I(cwe), .EXT_CARRY_I(cv), .RD_ADDR_I(rda),
    .RD_DATA_O(rdo), .TRUE_FALSE_FLAG_O(tf), .CARRY_FLAG_O(cy), .WB_VALID_O(wbv),
    .WB_ADDR_O(wba), .WB_DATA_O(wbd), .CMP_DONE_O(cmpd), .ILLEGAL_O(ill));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rwe  <= 1'b1;
    radr <= a;
    rdat <= d;
    @(posedge clk);
    rwe  <= 1'b0;
  endtask
  task automatic ext_flags(input logic f, input logic c);
    @(posedge clk);
    fwe <= 1'b1;
    fv  <= f;
    cwe <= 1'b1;
    cv  <= c;
    @(posedge clk);
    fwe <= 1'b0;
    cwe <= 1'b0;
  endtask
  // Returns just after the taking edge, while the result pulses stand
  task automatic exec(input logic [15:0] i);
    @(posedge clk);
    iv  <= 1'b1;
    ins <= i;
    @(posedge clk);
    iv  <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rda <= a;
    @(posedge clk);
    #1;
    d = rdo;
  endtask
  task automatic t_add();
    logic [31:0] v;
    wreg(4'h1, 32'h5);
    wreg(4'h2, 32'ha);
    ext_flags(1'b0, 1'b1);
    exec(16'h3a1f);
    exec(16'h3e12);
    exec(16'h3f12);
    exec(16'h3b12);
    rreg(4'h1, v);
    chk("add with flag clear", 32'he, v);
    ext_flags(1'b1, 1'b1);
    exec(16'h3e17);
    exec(16'h3f12);
    exec(16'h3a1f);
    exec(16'h3b12);
    rreg(4'h1, v);
    chk("add with flag set", 32'h1f, v);
    chk("flags after adds", 32'h3, {30'h0, tf, cy});
  endtask
  task automatic t_logic();
    logic [31:0] v;
    wreg(4'h3, 32'hf0f01234);
    wreg(4'h4, 32'h0ff0ff3c);
    exec(16'h2534);
    chk("and writeback data", 32'h00f01234, wbd);
    chk("and writeback index", 32'h13, {27'h0, wbv, wba});
    rreg(4'h3, v);
    chk("and", 32'h00f01234, v);
    exec(16'h5a36);
    rreg(4'h3, v);
    chk("and immediate", 32'h00000024, v);
    // Opcode outside this group: pulse only, no write, flags kept
    exec(16'h2134);
    chk("foreign op", 32'h13, {27'h0, ill, wbv, cmpd, tf, cy});
    rreg(4'h3, v);
    chk("foreign op register", 32'h00000024, v);
  endtask
  task automatic shift_case(input logic [15:0] i, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] v;
    logic [5:0]  n;
    logic [31:0] e;
    n = (i[15:8] == 8'h0f) ? {2'b00, i[3:0]} : b[5:0];
    // One sign-filling step per count; counts past 31 leave pure sign fill
    e = a;
    repeat (n) e = {e[31], e[31:1]};
    wreg(4'h5, a);
    wreg(4'h6, b);
    exec(i);
    rreg(4'h5, v);
    chk("shift", e, v);
  endtask
  task automatic t_shift();
    ext_flags(1'b0, 1'b0);
    shift_case(16'h0d56, 32'h80000010, 32'hffffffc4);
    shift_case(16'h0d56, 32'h87654321, 32'h00000021);
    shift_case(16'h0d56, 32'h7fffffff, 32'h0000003f);
    shift_case(16'h0d56, 32'h12345678, 32'h00000040);
    shift_case(16'h0f5f, 32'h87654321, 32'h0);
    shift_case(16'h0f50, 32'h80000001, 32'h0);
    chk("flags after shifts", 32'h0, {30'h0, tf, cy});
  endtask
  task automatic t_cmp();
    logic [80:0] c;
    logic [31:0] v;
    foreach (CMP_TAB[k])
    begin
      c = CMP_TAB[k];
      wreg(4'h8, c[64:33]);
      wreg(4'h9, c[32:1]);
      ext_flags(~c[0], 1'b1);
      exec(c[80:65]);
      chk("compare done", 32'h1, {31'h0, cmpd});
      rreg(4'h8, v);
      chk("compare flag", {31'h0, c[0]}, {31'h0, tf});
      chk("compare leaves register", c[64:33], v);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    {rst, iv, rwe, fwe, fv, cwe, cv} = 7'h40;
    ins = 16'h0;
    radr = 4'h0;
    rda = 4'h0;
    rdat = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset state", 32'h0, rdo | {30'h0, tf, cy});
    t_add();
    t_logic();
    t_shift();
    t_cmp();
    end_of_test();
  end
endmodule
